// ==== common/acbm_pkg.sv ====
// Constants, field positions and carrier types for the auxiliary control
// register and code bank map.
// Assumes one core clock and an SFR bus driven by the CPU core.
package acbm_pkg;

  // SFR addresses
  localparam logic [7:0] ACBM_AUX_ADDR = 8'hA2;
  localparam logic [7:0] ACBM_SFR_C0_ADDR = 8'hC0;

  // Field positions of auxiliary_control_one
  localparam int ACBM_EES_BIT = 7;
  localparam int ACBM_SP9_BIT = 6;
  localparam int ACBM_U2_BIT = 5;
  localparam int ACBM_GF_BIT = 3;
  localparam int ACBM_DPS_BIT = 0;

  // Reset value; undefined bits are resolved to zero
  localparam logic [7:0] ACBM_AUX_RESET = 8'h00;

  // Stack pointer wrap points
  localparam logic [7:0] ACBM_SP_TOP = 8'hFF;
  localparam logic [7:0] ACBM_SP_BOTTOM = 8'h00;

  // Code space geometry
  localparam int ACBM_CODE_AW = 16;
  localparam int ACBM_FLASH_AW = 17;
  localparam int ACBM_BANK_AW = 15;
  localparam int ACBM_ROM_AW = 12;
  localparam int ACBM_ROM_BYTES = 4096;
  localparam int ACBM_PAGE_SHIFT = 7;
  localparam int ACBM_PAGE_W = ACBM_FLASH_AW - ACBM_PAGE_SHIFT;
  localparam logic [1:0] ACBM_BANK_EXT = 2'h3;
  localparam logic [1:0] ACBM_BANK_STEP = 2'h1;
  localparam logic [1:0] ACBM_COMMON_SLOT = 2'h0;

  typedef enum logic [1:0] {
    ACBM_TGT_NONE,
    ACBM_TGT_FLASH,
    ACBM_TGT_ROM,
    ACBM_TGT_EXT
  } acbm_tgt_t;

  typedef struct packed {
    logic extended_stack_enable;
    logic sp9;
    logic u2;
    logic gf;
    logic data_pointer_select;
  } acbm_aux_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } acbm_sfr_req_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] sp;
  } acbm_stack_t;

  typedef struct packed {
    logic fetch;
    logic [ACBM_CODE_AW-1:0] addr;
  } acbm_fetch_t;

  typedef struct packed {
    logic valid;
    acbm_tgt_t tgt;
    logic [ACBM_FLASH_AW-1:0] flash_addr;
    logic [ACBM_PAGE_W-1:0] flash_page;
    logic [ACBM_CODE_AW-1:0] ext_addr;
    logic [ACBM_ROM_AW-1:0] rom_addr;
  } acbm_map_t;

endpackage

// ==== sim/acbm_core_model.sv ====
// Core-side model that issues SFR accesses, stack steps and code fetches.
// Assumes the bench calls its tasks and the clock keeps running.
`timescale 1ns/1ps
`default_nettype none
module acbm_core_model (
  input wire logic clock_i,
  output var acbm_pkg::acbm_sfr_req_t sfr_o,
  output var acbm_pkg::acbm_stack_t stack_o,
  output var acbm_pkg::acbm_fetch_t fetch_o
);
  import acbm_pkg::*;

  // Idle buses at time zero
  initial begin
    sfr_o = '0;
    stack_o = '0;
    fetch_o = '0;
  end

  // One SFR access; a software write to bit 6 is allowed but has no effect
  task automatic sfr_access(input logic wr, input logic rd, input logic [7:0] addr,
                            input logic [7:0] data);
    @(negedge clock_i);
    sfr_o.addr = addr;
    sfr_o.wdata = data & 8'hED;
    sfr_o.wr = wr;
    sfr_o.rd = rd;
    @(negedge clock_i);
    sfr_o.wr = 1'b0;
    sfr_o.rd = 1'b0;
    sfr_o.addr = ~addr; // Released bus must not keep its last value
    sfr_o.wdata = ~sfr_o.wdata;
  endtask

  // One stack step, pointer given as the value before the step
  task automatic stack_step(input logic push, input logic pop, input logic [7:0] ptr);
    @(negedge clock_i);
    stack_o.push = push;
    stack_o.pop = pop;
    stack_o.sp = ptr;
    @(negedge clock_i);
    stack_o.push = 1'b0;
    stack_o.pop = 1'b0;
    stack_o.sp = ~ptr;
  endtask

  // One code fetch
  task automatic fetch(input logic [15:0] addr);
    @(negedge clock_i);
    fetch_o.fetch = 1'b1;
    fetch_o.addr = addr;
    @(negedge clock_i);
    fetch_o.fetch = 1'b0;
    fetch_o.addr = ~addr;
  endtask
endmodule
`default_nettype wire

// ==== sim/test_aux_control_and_code_bank_map.sv ====
// Self-checking bench for the auxiliary control register and code bank map.
// Assumes the core model drives the SFR, stack and fetch inputs.
`timescale 1ns/1ps
`default_nettype none
module test_aux_control_and_code_bank_map;
  import acbm_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] bank_sel = 2'h0;
  logic pin = 1'b1;
  logic boot = 1'b0;
  acbm_sfr_req_t sfr;
  acbm_stack_t stk;
  acbm_fetch_t fch;
  acbm_map_t map;
  logic [7:0] rdata, w, aux;
  logic [8:0] saddr;
  logic rvalid, extended_stack_enable, hi, u2, gf, data_pointer_select, sel_ser, sel_port, in_expanded_ram;
  logic [15:0] a;
  int failures = 0;
  int n_tests = 0;
  int seed = 32'he2a3;
  int i;

  acbm_core_model core (.clock_i(clock_i), .sfr_o(sfr), .stack_o(stk), .fetch_o(fch));

  acbm_aux_bank DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .sfr_i(sfr), .stack_i(stk), .fetch_i(fch),
    .bank_sel_i(bank_sel), .external_access_pin_i(pin), .boot_active_i(boot),
    .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .extended_stack_enable_o(extended_stack_enable),
    .stack_pointer_high_bit_o(hi), .port_remap_select_o(u2), .general_user_flag_o(gf),
    .data_pointer_select_o(data_pointer_select), .sel_second_serial_control_o(sel_ser),
    .sel_fourth_io_port_o(sel_port), .stack_addr_o(saddr),
    .stack_in_expanded_ram_o(in_expanded_ram), .map_o(map)
  );

  // Free-running core clock, 8 ns
  initial begin
    forever #4 clock_i = ~clock_i;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read back the register in the one-cycle answer window
  task automatic rd_check(input logic [7:0] exp);
    core.sfr_access(1'b0, 1'b1, ACBM_AUX_ADDR, 8'h00);
    check(64'(rvalid), 64'(1'b1), "read valid");
    check(64'(rdata), 64'(exp), "aux read");
    @(negedge clock_i);
    check(64'({rvalid, rdata}), 64'(9'h000), "answer gone");
  endtask

  // Expected decode of one fetch; unused address fields stay zero
  function automatic acbm_map_t exp_map(input logic [15:0] ad, input logic [1:0] b,
                                        input logic p, input logic bt);
    acbm_map_t m;
    m = '0;
    m.valid = 1'b1;
    m.tgt = ACBM_TGT_FLASH;
    if (!p) begin
      m.tgt = ACBM_TGT_EXT;
      m.ext_addr = ad;
    end else if (bt && 32'(ad) < ACBM_ROM_BYTES) begin
      m.tgt = ACBM_TGT_ROM;
      m.rom_addr = ad[11:0];
    end else if (!ad[15]) begin
      m.flash_addr = {2'h0, ad[14:0]};
    end else if (b == 2'h3) begin
      m.tgt = ACBM_TGT_EXT;
      m.ext_addr = ad;
    end else begin
      m.flash_addr = {b + 2'h1, ad[14:0]};
    end
    m.flash_page = m.flash_addr[16:7];
    return m;
  endfunction

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    rd_check(8'h00);
    check(64'(extended_stack_enable), 64'(1'b0), "extension off after reset");
    // Random writes, first one all ones to hit every field and fixed bits 6 and 2
    for (i = 0; i < 24; i++) begin
      w = (i == 0) ? 8'hFF : 8'($random(seed));
      core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, w);
      aux = {w[7], 1'b0, w[5], 1'b0, w[3], 2'b00, w[0]};
      check(64'({extended_stack_enable, u2, gf, data_pointer_select}), 64'({w[7], w[5], w[3], w[0]}), "fields");
      rd_check(aux);
    end
    // Other addresses leave the register alone
    core.sfr_access(1'b1, 1'b0, 8'hA3, ~aux);
    rd_check(aux);
    // Read and write together: old value answers, write lands
    w = ~aux;
    core.sfr_access(1'b1, 1'b1, ACBM_AUX_ADDR, w);
    check(64'({rvalid, rdata}), 64'({1'b1, aux}), "read beside write");
    aux = w & 8'hA9;
    rd_check(aux);
    // Remap select steers the C0h decode
    for (i = 0; i < 2; i++) begin
      core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, 8'(i << 5));
      core.sfr_access(1'b0, 1'b1, ACBM_SFR_C0_ADDR, 8'h00);
      check(64'({sel_ser, sel_port}), 64'({i == 0, i == 1}), "C0 decode");
      core.sfr_access(1'b1, 1'b0, ACBM_SFR_C0_ADDR, 8'h00);
      check(64'({sel_ser, sel_port}), 64'({i == 0, i == 1}), "C0 write decode");
    end
    // Wrap with extension off must not reach the ninth bit
    core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, 8'h00);
    core.stack_step(1'b1, 1'b0, 8'hFF);
    check(64'({in_expanded_ram, saddr}), 64'(10'h000), "stack off");
    core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, 8'h80);
    core.stack_step(1'b1, 1'b0, 8'hFF);
    check(64'({in_expanded_ram, hi, saddr}), 64'(11'h700), "push into expanded_ram");
    rd_check(8'hC0);
    core.stack_step(1'b1, 1'b1, 8'h10);
    check(64'(saddr), 64'(9'h110), "push and pop");
    core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, 8'hC0);
    rd_check(8'hC0);
    core.stack_step(1'b0, 1'b1, 8'h00);
    check(64'({in_expanded_ram, hi, saddr}), 64'(11'h0FF), "pop to internal");
    core.sfr_access(1'b1, 1'b0, ACBM_AUX_ADDR, 8'hC0);
    rd_check(8'h80);
    // Mid-run reset with the high bit set clears every output
    core.stack_step(1'b1, 1'b0, 8'hFF);
    check(64'(hi), 64'(1'b1), "high bit before reset");
    nrst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    check(64'({extended_stack_enable, hi, u2, gf, data_pointer_select, in_expanded_ram, saddr}), 64'(0), "fields after reset");
    check(64'({sel_ser, sel_port, rvalid, rdata}), 64'(0), "answers after reset");
    check(64'(map), 64'(0), "map after reset");
    rd_check(8'h00);
    // Code map: boundary addresses first, then random
    for (i = 0; i < 80; i++) begin
      a = 16'($random(seed));
      bank_sel = 2'($random(seed));
      boot = 1'($random(seed));
      pin = (i % 7) != 3;
      if (i < 16) begin
        a = (i % 4 == 0) ? 16'h0FFF : (i % 4 == 1) ? 16'h1000 : (i % 4 == 2) ? 16'h7FFF : 16'h8000;
        bank_sel = 2'(i / 4);
      end
      core.fetch(a);
      check(64'(map), 64'(exp_map(a, bank_sel, pin, boot)), "code map");
    end
    // Decode stands one cycle, then the map goes idle
    @(negedge clock_i);
    check(64'(map), 64'(0), "map idle");
    final_report();
  end
endmodule
`default_nettype wire

// ==== src/acbm_aux_bank.sv ====
// Auxiliary control register on the SFR bus with stack extension tracking,
// C0h remap decode, data pointer select and the code bank map.
// Assumes the core presents one SFR access per cycle and reports each
// stack push or pop in the cycle in which the stack pointer steps.
`timescale 1ns/1ps
`default_nettype none
module acbm_aux_bank #(
  parameter int ROM_BYTES = acbm_pkg::ACBM_ROM_BYTES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire acbm_pkg::acbm_sfr_req_t sfr_i,
  input wire acbm_pkg::acbm_stack_t stack_i,
  input wire acbm_pkg::acbm_fetch_t fetch_i,
  input wire logic [1:0] bank_sel_i,
  input wire logic external_access_pin_i,
  input wire logic boot_active_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_rvalid_o,
  output logic extended_stack_enable_o,
  output logic stack_pointer_high_bit_o,
  output logic port_remap_select_o,
  output logic general_user_flag_o,
  output logic data_pointer_select_o,
  output logic sel_second_serial_control_o,
  output logic sel_fourth_io_port_o,
  output logic [8:0] stack_addr_o,
  output logic stack_in_expanded_ram_o,
  output var acbm_pkg::acbm_map_t map_o
);
  import acbm_pkg::*;

  // All block state in one record
  typedef struct packed {
    acbm_aux_t aux;
    logic [7:0] rdata;
    logic rvalid;
    logic sel_serial;
    logic sel_port;
    logic [8:0] stack_addr;
    logic stack_expanded_ram;
  } acbm_state_t;

  acbm_state_t st_ff;
  acbm_state_t nxt_st;

  logic aux_hit;
  logic c0_hit;
  logic push_wrap;
  logic pop_wrap;
  logic [7:0] sp_step;
  logic [7:0] aux_view;

  // Address decode of the SFR bus
  assign aux_hit = (sfr_i.addr == ACBM_AUX_ADDR);
  assign c0_hit = (sfr_i.addr == ACBM_SFR_C0_ADDR) && (sfr_i.wr || sfr_i.rd);

  // Nine-bit pointer carries and borrows out of the low byte
  assign push_wrap = stack_i.push && !stack_i.pop && (stack_i.sp == ACBM_SP_TOP);
  assign pop_wrap = stack_i.pop && !stack_i.push && (stack_i.sp == ACBM_SP_BOTTOM);

  // Low byte after this cycle's step
  always_comb begin
    sp_step = stack_i.sp;
    if (stack_i.push && !stack_i.pop) begin
      sp_step = 8'(stack_i.sp + 8'h01);
    end else if (stack_i.pop && !stack_i.push) begin
      sp_step = 8'(stack_i.sp - 8'h01);
    end
  end

  // Read view; reserved bits and bit 2 read as zero
  always_comb begin
    aux_view = 8'h00;
    aux_view[ACBM_EES_BIT] = st_ff.aux.extended_stack_enable;
    aux_view[ACBM_SP9_BIT] = st_ff.aux.sp9;
    aux_view[ACBM_U2_BIT] = st_ff.aux.u2;
    aux_view[ACBM_GF_BIT] = st_ff.aux.gf;
    aux_view[ACBM_DPS_BIT] = st_ff.aux.data_pointer_select;
  end

  // Next state: software fields, hardware stack bit, decodes
  always_comb begin
    nxt_st = st_ff;

    // Software fields; bit 6 and reserved bits are never written
    if (sfr_i.wr && aux_hit) begin
      nxt_st.aux.extended_stack_enable = sfr_i.wdata[ACBM_EES_BIT];
      nxt_st.aux.u2 = sfr_i.wdata[ACBM_U2_BIT];
      nxt_st.aux.gf = sfr_i.wdata[ACBM_GF_BIT];
      nxt_st.aux.data_pointer_select = sfr_i.wdata[ACBM_DPS_BIT];
    end

    // Ninth pointer bit flips on carry or borrow, only while extended
    if (st_ff.aux.extended_stack_enable && (push_wrap || pop_wrap)) begin
      nxt_st.aux.sp9 = !st_ff.aux.sp9;
    end

    // Read answer one cycle after the strobe, zero otherwise
    nxt_st.rvalid = sfr_i.rd && aux_hit;
    nxt_st.rdata = (sfr_i.rd && aux_hit) ? aux_view : 8'h00;

    // C0h steering uses the remap bit as it stands before any write
    nxt_st.sel_serial = c0_hit && !st_ff.aux.u2;
    nxt_st.sel_port = c0_hit && st_ff.aux.u2;

    // High bit gated by the enable so a stale value cannot leak out
    nxt_st.stack_expanded_ram = nxt_st.aux.extended_stack_enable && nxt_st.aux.sp9;
    nxt_st.stack_addr = {nxt_st.stack_expanded_ram, sp_step};
  end

  // State register; undefined reset bits resolved to zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nxt_reset_hold: begin
        st_ff <= '0;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output except map_o straight from the state register; map_o comes from the register in u_code_map
  assign sfr_rdata_o = st_ff.rdata;
  assign sfr_rvalid_o = st_ff.rvalid;
  assign extended_stack_enable_o = st_ff.aux.extended_stack_enable;
  assign stack_pointer_high_bit_o = st_ff.aux.sp9;
  assign port_remap_select_o = st_ff.aux.u2;
  assign general_user_flag_o = st_ff.aux.gf;
  assign data_pointer_select_o = st_ff.aux.data_pointer_select;
  assign sel_second_serial_control_o = st_ff.sel_serial;
  assign sel_fourth_io_port_o = st_ff.sel_port;
  assign stack_addr_o = st_ff.stack_addr;
  assign stack_in_expanded_ram_o = st_ff.stack_expanded_ram;

  // Code fetch decoding kept apart from the data side
  acbm_code_map #(
    .ROM_BYTES(ROM_BYTES)
  ) u_code_map (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .fetch_i(fetch_i),
    .bank_sel_i(bank_sel_i),
    .external_access_pin_i(external_access_pin_i),
    .boot_active_i(boot_active_i),
    .map_o(map_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // A write followed by three quiet cycles
  sequence s_aux_write_then_quiet;
    (sfr_i.wr && aux_hit) ##1 !(sfr_i.wr && aux_hit) [*3];
  endsequence

  // A push out of the top byte while extended
  sequence s_push_out;
    st_ff.aux.extended_stack_enable && push_wrap && !stack_pointer_high_bit_o &&
    !(sfr_i.wr && aux_hit);
  endsequence

  a_ees_write: assert property (sfr_i.wr && aux_hit |=>
    extended_stack_enable_o == $past(sfr_i.wdata[7]))
    else $error("extended stack enable did not follow write");

  a_sp9_masked: assert property (!extended_stack_enable_o |->
    !stack_addr_o[8] && !stack_in_expanded_ram_o)
    else $error("high stack bit leaked while disabled");

  a_sp9_enter_expanded_ram: assert property (s_push_out |=>
    stack_pointer_high_bit_o && stack_addr_o == 9'h100)
    else $error("push past top did not enter expanded ram");

  a_sp9_hw_only: assert property (!(st_ff.aux.extended_stack_enable && (push_wrap || pop_wrap)) |=>
    $stable(stack_pointer_high_bit_o))
    else $error("high stack bit changed without carry or borrow");

  a_c0_routing: assert property (c0_hit |=>
    sel_fourth_io_port_o == $past(port_remap_select_o) &&
    sel_second_serial_control_o == !$past(port_remap_select_o))
    else $error("C0h routed against remap bit");

  a_gf_retain: assert property (s_aux_write_then_quiet |->
    general_user_flag_o == $past(sfr_i.wdata[3], 3))
    else $error("user flag lost its written value");

  a_reserved_zero: assert property (sfr_rvalid_o |->
    sfr_rdata_o[4] == 1'b0 && sfr_rdata_o[1] == 1'b0 && sfr_rdata_o[2] == 1'b0)
    else $error("reserved or zero bit read as one");

  a_dps_write: assert property (sfr_i.wr && aux_hit |=>
    data_pointer_select_o == $past(sfr_i.wdata[0]))
    else $error("data pointer select did not follow write");

  a_read_answer: assert property (sfr_i.rd && aux_hit |=>
    sfr_rvalid_o && sfr_rdata_o[7] == $past(extended_stack_enable_o) &&
    sfr_rdata_o[6] == $past(stack_pointer_high_bit_o))
    else $error("read answer missing or wrong");

  a_no_stray_read: assert property (!(sfr_i.rd && aux_hit) |=>
    !sfr_rvalid_o && sfr_rdata_o == 8'h00)
    else $error("read answer without an access");

  a_pop_leave_expanded_ram: assert property (st_ff.aux.extended_stack_enable && pop_wrap &&
    stack_pointer_high_bit_o |=> !stack_pointer_high_bit_o && stack_addr_o == 9'h0FF)
    else $error("pop below expanded ram did not return");

  // One write to the register, and one lone stack step either way
  sequence s_aux_write;
    sfr_i.wr && aux_hit;
  endsequence

  sequence s_lone_push;
    stack_i.push && !stack_i.pop;
  endsequence

  sequence s_lone_pop;
    stack_i.pop && !stack_i.push;
  endsequence

  // Remap select follows a write
  a_u2_write: assert property (s_aux_write |=>
    port_remap_select_o == $past(sfr_i.wdata[5]))
    else $error("remap select did not follow write");

  // User flag is plain storage
  a_gf_write: assert property (s_aux_write |=>
    general_user_flag_o == $past(sfr_i.wdata[3]))
    else $error("user flag did not follow write");

  // Software fields hold between writes
  a_fields_hold: assert property (!(sfr_i.wr && aux_hit) |=>
    $stable({extended_stack_enable_o, port_remap_select_o, general_user_flag_o,
             data_pointer_select_o}))
    else $error("software field changed without a write");

  // A write never reaches the hardware stack bit
  a_write_keeps_sp9: assert property (s_aux_write ##0
    !(st_ff.aux.extended_stack_enable && (push_wrap || pop_wrap)) |=> $stable(stack_pointer_high_bit_o))
    else $error("write disturbed the high stack bit");

  // Wraps while disabled leave the high bit where it was
  a_wrap_off_hold: assert property (!st_ff.aux.extended_stack_enable && (push_wrap || pop_wrap) |=>
    $stable(stack_pointer_high_bit_o))
    else $error("high stack bit moved while extension disabled");

  // Carry or borrow out of the low byte flips the high bit while extended
  a_sp9_flip: assert property (st_ff.aux.extended_stack_enable && (push_wrap || pop_wrap) |=>
    stack_pointer_high_bit_o != $past(stack_pointer_high_bit_o))
    else $error("high stack bit missed a carry or borrow");

  // Low pointer byte steps up once per lone push
  a_push_step: assert property (s_lone_push |=>
    stack_addr_o[7:0] == 8'($past(stack_i.sp) + 8'h01))
    else $error("push did not step the pointer up");

  // Low pointer byte steps down once per lone pop
  a_pop_step: assert property (s_lone_pop |=>
    stack_addr_o[7:0] == 8'($past(stack_i.sp) - 8'h01))
    else $error("pop did not step the pointer down");

  // Push and pop together, or neither, leave the byte as reported
  a_no_step: assert property (stack_i.push == stack_i.pop |=>
    stack_addr_o[7:0] == $past(stack_i.sp))
    else $error("pointer moved without a lone push or pop");

  // Expanded ram only while enabled and the high bit is set
  a_expanded_ram_flag: assert property (stack_in_expanded_ram_o ==
    (extended_stack_enable_o && stack_pointer_high_bit_o))
    else $error("expanded ram flag disagrees with enable and high bit");

  // Remaining bits of the read answer
  a_read_low_bits: assert property (sfr_i.rd && aux_hit |=>
    sfr_rdata_o[5] == $past(port_remap_select_o) &&
    sfr_rdata_o[3] == $past(general_user_flag_o) &&
    sfr_rdata_o[0] == $past(data_pointer_select_o))
    else $error("read answer low bits wrong");

  // C0h selects only after an access there
  a_c0_idle: assert property (!c0_hit |=>
    !sel_second_serial_control_o && !sel_fourth_io_port_o)
    else $error("C0h select without an access");
endmodule
`default_nettype wire

// ==== src/acbm_code_map.sv ====
// Registered code fetch decoder: common area, flash banks, boot ROM, external.
// Assumes bank select and external access level are stable around a fetch.
`timescale 1ns/1ps
`default_nettype none
module acbm_code_map #(
  parameter int ROM_BYTES = acbm_pkg::ACBM_ROM_BYTES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire acbm_pkg::acbm_fetch_t fetch_i,
  input wire logic [1:0] bank_sel_i,
  input wire logic external_access_pin_i,
  input wire logic boot_active_i,
  output var acbm_pkg::acbm_map_t map_o
);
  import acbm_pkg::*;

  localparam logic [ACBM_CODE_AW:0] ROM_LIMIT = (ACBM_CODE_AW+1)'(ROM_BYTES);

  // ROM address field is fixed at 12 bits
  generate
    if (ROM_BYTES <= 0 || ROM_BYTES > (1 << ACBM_ROM_AW) ||
        (ROM_BYTES & (ROM_BYTES - 1)) != 0) begin : g_bad_rom
      $error("acbm_code_map: ROM_BYTES must be a power of two up to 4096");
    end
  endgenerate

  acbm_map_t map_ff;
  acbm_map_t nxt_map;

  // Priority: pin low, then boot ROM, then lower half, then bank
  always_comb begin
    nxt_map = '0;
    nxt_map.valid = fetch_i.fetch;
    nxt_map.tgt = ACBM_TGT_NONE;
    if (fetch_i.fetch) begin
      if (!external_access_pin_i) begin
        nxt_map.tgt = ACBM_TGT_EXT;
        nxt_map.ext_addr = fetch_i.addr;
      end else if (boot_active_i && ({1'b0, fetch_i.addr} < ROM_LIMIT)) begin
        nxt_map.tgt = ACBM_TGT_ROM;
        nxt_map.rom_addr = fetch_i.addr[ACBM_ROM_AW-1:0];
      end else if (!fetch_i.addr[ACBM_CODE_AW-1]) begin
        nxt_map.tgt = ACBM_TGT_FLASH;
        nxt_map.flash_addr = {ACBM_COMMON_SLOT, fetch_i.addr[ACBM_BANK_AW-1:0]};
      end else if (bank_sel_i == ACBM_BANK_EXT) begin
        nxt_map.tgt = ACBM_TGT_EXT;
        nxt_map.ext_addr = fetch_i.addr;
      end else begin
        nxt_map.tgt = ACBM_TGT_FLASH;
        nxt_map.flash_addr = {2'(bank_sel_i + ACBM_BANK_STEP),
                              fetch_i.addr[ACBM_BANK_AW-1:0]};
      end
    end
    // Page index of a 128-byte flash page
    nxt_map.flash_page = nxt_map.flash_addr[ACBM_FLASH_AW-1:ACBM_PAGE_SHIFT];
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      map_ff <= '0;
    end else begin
      map_ff <= nxt_map;
    end
  end

  assign map_o = map_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_pin_low_ext: assert property (fetch_i.fetch && !external_access_pin_i |=>
    map_o.tgt == ACBM_TGT_EXT && map_o.ext_addr == $past(fetch_i.addr))
    else $error("fetch with pin low not external");
  a_bank_ext_route: assert property (fetch_i.fetch && external_access_pin_i &&
    fetch_i.addr[15] && bank_sel_i == ACBM_BANK_EXT |=> map_o.tgt == ACBM_TGT_EXT)
    else $error("external bank fetch not external");
  a_lower_common: assert property (fetch_i.fetch && external_access_pin_i &&
    !boot_active_i && !fetch_i.addr[15] |=>
    map_o.tgt == ACBM_TGT_FLASH && map_o.flash_addr[16:15] == ACBM_COMMON_SLOT)
    else $error("lower half not in common area");
  a_upper_bank: assert property (fetch_i.fetch && external_access_pin_i &&
    fetch_i.addr[15] && bank_sel_i != ACBM_BANK_EXT |=>
    map_o.flash_addr[16:15] == 2'($past(bank_sel_i) + ACBM_BANK_STEP))
    else $error("upper bank slot wrong");
endmodule
`default_nettype wire
